// ==== inc/cbt_pkg.sv ====
// Package: register map, field layout and types for CAN bit timing
package cbt_pkg;
    // Register byte offsets
    localparam logic [7:0] CBT_OFF_PRESCALE = 8'h00; // bit_prescaler_reg
    localparam logic [7:0] CBT_OFF_SYNC = 8'h04; // bit_sync_reg
    localparam logic [7:0] CBT_OFF_CHDEF = 8'h08; // channel_definition_reg
    localparam logic [7:0] CBT_OFF_BUFCFG = 8'h0C; // buffer_config_reg
    localparam logic [7:0] CBT_OFF_STATUS = 8'h10; // Flags and bit state
    localparam logic [7:0] CBT_OFF_STAMP = 8'h14; // Captured timer value
    // Field positions
    localparam int CBT_PRE_EXT_BIT = 8; // prescale_range_ext
    localparam int CBT_CH_TSEL = 0; // timestamp_point_sel
    localparam int CBT_CH_OVW = 1; // overwrite_enable
    localparam int CBT_CH_TXPOL = 2; // tx_dominant_polarity
    localparam int CBT_CH_RXPOL = 3; // rx_dominant_polarity
    localparam int CBT_ST_NEWDATA = 0; // new_data_flag, write 1 clears
    // Reset values
    localparam logic [8:0] CBT_PRE_RST = 9'h000;
    localparam logic [15:0] CBT_SYNC_RST = 16'h0000;
    localparam logic [3:0] CBT_CHDEF_RST = 4'h0;
    localparam logic [5:0] CBT_BUFCFG_RST = 6'h00;
    // Bit length limits in quanta minus one
    localparam logic [4:0] CBT_DBT_MIN = 5'h07;
    localparam logic [4:0] CBT_DBT_MAX = 5'h18;
    // Supply clocks in one information processing time
    localparam int CBT_IPT_CLKS = 3;
    // AXI responses
    localparam logic [1:0] CBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;

    // Synchronisation register layout
    typedef struct packed {
        logic [3:0] rsv;
        logic [1:0] sjw; // Jump width minus one
        logic [4:0] spt; // sample_point_field
        logic [4:0] dbt; // bit_length_field
    } cbt_sync_t;

    // Buffer configuration layout
    typedef struct packed {
        logic [2:0] owner; // buffer_owner_field
        logic [2:0] btype; // buffer_type_field
    } cbt_bufcfg_t;

    // Buffer type decode
    typedef enum logic [2:0] {
        CBT_BT_TX = 3'h0,
        CBT_BT_RX = 3'h1,
        CBT_BT_RXM0 = 3'h2,
        CBT_BT_RXM1 = 3'h3,
        CBT_BT_RXM2 = 3'h4,
        CBT_BT_RXM3 = 3'h5,
        CBT_BT_DIAG = 3'h7
    } cbt_btype_t;

    // Buffer owner codes
    localparam logic [2:0] CBT_OWN_FREE = 3'h0;
    localparam logic [2:0] CBT_OWN_CH1 = 3'h1;
    localparam logic [2:0] CBT_OWN_CH2 = 3'h2;
endpackage : cbt_pkg

// ==== core/cbt_core.sv ====
// CAN bit timing, synchronisation and channel settings with AXI4-Lite
//
// Notes on behaviour
// - Prescaler divides base clock, 2..128 or 2..256
// - Bit spans 8 to 25 quanta
// - Sync segment one quantum, starts each bit, each hard sync and each resync within jump width
// - Propagation segment 1 to 8 quanta
// - Phase segment 1 is 1 to 8 quanta
// - Phase 2 is max of phase 1, INFO_PROCESSING_TIME; here the rest of the bit, at least INFO_PROCESSING_TIME
// - Jump width 1 to 4 quanta bounds adjustment
// - INFO_PROCESSING_TIME equals three supply clock periods
// - Transmitter uses own timing, receiver follows edges
// - Idle falling edge: sync now, prop next
// - Hard sync at first change after reset or wakeup, and at each dominant edge on an idle bus
// - Resync only if previous sample recessive
// - Phase error zero, positive or negative
// - Edge within jump width: sync like hard
// - Positive beyond jump width: lengthen phase 1
// - Negative beyond jump width: shorten phase 2
// - Timestamp at end or start of frame
// - Overwrite bit decides fate of new message
// - Buffer type field encoding
// - Buffer owner field encoding
// - Quantum clock is base over 2(a+1)
// - Sample point and bit length field layout
// - Jump width is field plus one
`timescale 1ns/1ps
`default_nettype none
module cbt_core
    import cbt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic can_rx_pin,
    output logic can_tx_pin,
    input wire logic tx_active,
    input wire logic tx_bit,
    input wire logic bus_idle,
    input wire logic wakeup,
    input wire logic frame_sof,
    input wire logic frame_eof,
    input wire logic [15:0] timer_value,
    input wire logic msg_store,
    output logic msg_accept,
    output logic msg_discard,
    output logic bit_start,
    output logic sample_strobe,
    output logic rx_bit,
    output logic buf_is_tx,
    output logic buf_is_rx,
    output logic buf_mask_use,
    output logic [1:0] buf_mask_sel,
    output logic buf_diag,
    output logic [1:0] buf_channel
);
    // Registers
    logic [8:0] pre_r; // Prescale value and range extension
    cbt_sync_t sync_r; // Segment settings
    logic [3:0] chdef_r; // Channel definition bits
    cbt_bufcfg_t bufcfg_r; // Buffer configuration
    logic newdata_r; // New data held in buffer
    logic [15:0] stamp_r; // Captured timer value
    // Bus side
    logic aw_held_r, w_held_r; // Write halves taken
    logic [7:0] aw_addr_r; // Held write address
    logic [31:0] w_data_r; // Held write data
    logic [3:0] w_strb_r; // Held strobes
    logic wr_fire; // Both halves present
    logic nd_clear; // Software clears new data
    // Timing
    logic [7:0] div_r; // Base clock divider
    logic [7:0] div_term; // Divider terminal count
    logic tq_tick; // One pulse per quantum
    logic [4:0] q_r; // Quantum index in bit
    logic [2:0] ext_r; // Phase 1 lengthening
    logic [2:0] shr_r; // Phase 2 shortening
    logic [4:0] dbt_c; // Clamped bit length minus one
    logic [4:0] spt_c; // Sample field, kept inside the bit
    logic [4:0] seg_end; // Last quantum index
    logic [4:0] end_eff; // Adjusted last index
    logic [4:0] smp_q; // Sample quantum index
    logic [2:0] sjw_q; // Jump width in quanta
    logic [4:0] ipt_q; // INFO_PROCESSING_TIME in quanta
    logic bit_end; // Last quantum of bit
    // Receive path
    logic rx_s1_r, rx_s2_r; // Pin synchroniser
    logic rx_dom; // Level is dominant
    logic prev_dom_r; // Level at previous quantum
    logic edge_det; // Level changed this quantum
    logic hard_done_r; // Hard sync taken
    logic hard_sync; // Hard sync now
    logic resync; // Resync now
    logic pos_err, neg_err; // Error sign
    logic [4:0] err_mag; // Error size in quanta
    logic tx_pin_r; // Transmit pin flop
    logic acc_r, disc_r; // Message outcome pulses

    // Buffer type to role
    function automatic logic [1:0] cbt_role(input logic [2:0] t);
        logic [1:0] r;
        r = 2'h0;
        if (t == CBT_BT_TX) begin
            r = 2'h1;
        end else if (t >= CBT_BT_RX && t <= CBT_BT_RXM3) begin
            r = 2'h2;
        end else if (t == CBT_BT_DIAG) begin
            r = 2'h3;
        end
        return r;
    endfunction : cbt_role

    // Buffer decode outputs
    always_comb begin
        buf_is_tx = cbt_role(bufcfg_r.btype) == 2'h1;
        buf_is_rx = cbt_role(bufcfg_r.btype) == 2'h2;
        buf_diag = cbt_role(bufcfg_r.btype) == 2'h3;
        buf_mask_use = buf_is_rx && bufcfg_r.btype != CBT_BT_RX;
        buf_mask_sel = 2'(bufcfg_r.btype - CBT_BT_RXM0);
        // Free buffer or unknown owner belongs to nobody
        buf_channel = 2'h0;
        if (bufcfg_r.owner == CBT_OWN_CH1) begin
            buf_channel = 2'h1;
        end else if (bufcfg_r.owner == CBT_OWN_CH2) begin
            buf_channel = 2'h2;
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_fire = aw_held_r && w_held_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CBT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Addresses above the timestamp register answer with slave error
                s_axi_bresp <= (aw_addr_r[7:2] > CBT_OFF_STAMP[7:2]) ?
                    CBT_RESP_SLVERR : CBT_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration writes, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_r <= CBT_PRE_RST;
            sync_r <= CBT_SYNC_RST;
            chdef_r <= CBT_CHDEF_RST;
            bufcfg_r <= CBT_BUFCFG_RST;
        end else if (wr_fire) begin
            unique case (aw_addr_r)
                CBT_OFF_PRESCALE: begin
                    if (w_strb_r[0]) pre_r[7:0] <= w_data_r[7:0];
                    if (w_strb_r[1]) pre_r[8] <= w_data_r[CBT_PRE_EXT_BIT];
                end
                CBT_OFF_SYNC: begin
                    if (w_strb_r[0]) sync_r[7:0] <= w_data_r[7:0];
                    if (w_strb_r[1]) sync_r[11:8] <= w_data_r[11:8];
                end
                CBT_OFF_CHDEF: begin
                    if (w_strb_r[0]) chdef_r <= w_data_r[3:0];
                end
                CBT_OFF_BUFCFG: begin
                    if (w_strb_r[0]) bufcfg_r <= w_data_r[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read channel: answer one cycle after address
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= CBT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CBT_RESP_OKAY;
            unique case (s_axi_araddr)
                CBT_OFF_PRESCALE: s_axi_rdata <= {23'h0, pre_r};
                CBT_OFF_SYNC: s_axi_rdata <= {20'h0, sync_r[11:0]};
                CBT_OFF_CHDEF: s_axi_rdata <= {28'h0, chdef_r};
                CBT_OFF_BUFCFG: s_axi_rdata <= {26'h0, bufcfg_r};
                CBT_OFF_STATUS: begin
                    s_axi_rdata <= {24'h0, q_r, rx_bit, hard_done_r,
                        newdata_r};
                end
                CBT_OFF_STAMP: s_axi_rdata <= {16'h0, stamp_r};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= CBT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Quantum clock: ratio 2(a+1), ext adds a seventh bit to a
    assign div_term = {pre_r[8] & pre_r[6], pre_r[5:0], 1'b1};
    assign tq_tick = div_r == div_term;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 8'h00;
        end else begin
            div_r <= tq_tick ? 8'h00 : div_r + 8'h01;
        end
    end

    // Segment arithmetic; settings outside range are clamped
    always_comb begin
        dbt_c = sync_r.dbt;
        if (dbt_c < CBT_DBT_MIN) dbt_c = CBT_DBT_MIN;
        if (dbt_c > CBT_DBT_MAX) dbt_c = CBT_DBT_MAX;
        sjw_q = {1'b0, sync_r.sjw} + 3'h1;
        // Three supply clocks fill two quanta only at ratio two
        ipt_q = (div_term < 8'(CBT_IPT_CLKS)) ? 5'h2 : 5'h1;
        // Sample field capped so the bit never outgrows 25 quanta before phase 1 lengthening
        spt_c = sync_r.spt;
        if (spt_c > 5'(CBT_DBT_MAX - ipt_q)) spt_c = 5'(CBT_DBT_MAX - ipt_q);
        seg_end = dbt_c;
        if (spt_c + ipt_q > dbt_c) seg_end = 5'(spt_c + ipt_q);
        smp_q = 5'(spt_c + ext_r);
        end_eff = 5'(seg_end + ext_r - shr_r);
        // Also ends a bit that a settings change left beyond its end
        bit_end = q_r >= end_eff;
    end

    // Receive pin: two flops, then polarity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= can_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end
    assign rx_dom = rx_s2_r == chdef_r[CBT_CH_RXPOL];

    // Edge classification against the quantum position
    always_comb begin
        edge_det = tq_tick && (rx_dom != prev_dom_r);
        // First change after reset, or idle start of frame
        hard_synch_calc: begin
            hard_sync = edge_det && (!hard_done_r ||
                (bus_idle && rx_dom));
        end
        // Transmitter keeps own timing; only after recessive sample
        resync = edge_det && !hard_sync && !tx_active &&
            rx_bit;
        pos_err = q_r != 5'h0 && q_r <= smp_q;
        neg_err = q_r > smp_q;
        err_mag = pos_err ? q_r : 5'(end_eff - q_r + 5'h1);
    end

    // Bit sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= 5'h0;
            ext_r <= 3'h0;
            shr_r <= 3'h0;
            prev_dom_r <= 1'b0;
        end else if (tq_tick) begin
            prev_dom_r <= rx_dom;
            if (hard_sync || (resync && (pos_err || neg_err) &&
                    err_mag <= 5'(sjw_q))) begin
                // Edge quantum became sync, prop follows
                q_r <= 5'h1;
                ext_r <= 3'h0;
                shr_r <= 3'h0;
            end else begin
                if (resync && pos_err) begin
                    ext_r <= sjw_q;
                end else if (resync && neg_err) begin
                    shr_r <= sjw_q;
                end
                if (bit_end) begin
                    q_r <= 5'h0;
                    ext_r <= 3'h0;
                    shr_r <= 3'h0;
                end else begin
                    q_r <= q_r + 5'h1;
                end
            end
        end
    end

    // Hard sync is armed by reset or wakeup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hard_done_r <= 1'b0;
        end else if (wakeup) begin
            hard_done_r <= 1'b0;
        end else if (hard_sync) begin
            hard_done_r <= 1'b1;
        end
    end

    // Sample point and transmit pin
    assign sample_strobe = tq_tick && q_r == smp_q && !hard_sync;
    assign bit_start = tq_tick && bit_end && !hard_sync;
    assign can_tx_pin = tx_pin_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit <= 1'b1;
            tx_pin_r <= 1'b1;
        end else begin
            if (sample_strobe) rx_bit <= !rx_dom;
            // Pin changes only at our own bit boundary
            if (bit_start) begin
                tx_pin_r <= (tx_active && !tx_bit) ==
                    chdef_r[CBT_CH_TXPOL];
            end
        end
    end

    // Timestamp capture point
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stamp_r <= 16'h0000;
        end else if (chdef_r[CBT_CH_TSEL] ? frame_eof : frame_sof) begin
            stamp_r <= timer_value;
        end
    end

    // Store or drop; hardware set beats software clear
    assign nd_clear = wr_fire && aw_addr_r == CBT_OFF_STATUS &&
        w_strb_r[0] && w_data_r[CBT_ST_NEWDATA];
    assign msg_accept = acc_r;
    assign msg_discard = disc_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            newdata_r <= 1'b0;
            acc_r <= 1'b0;
            disc_r <= 1'b0;
        end else begin
            acc_r <= msg_store && (!newdata_r || chdef_r[CBT_CH_OVW]);
            disc_r <= msg_store && newdata_r && !chdef_r[CBT_CH_OVW];
            if (msg_store && (!newdata_r || chdef_r[CBT_CH_OVW])) begin
                newdata_r <= 1'b1;
            end else if (nd_clear) begin
                newdata_r <= 1'b0;
            end
        end
    end

    // Checks
    a_div_period: assert property (@(posedge aclk) disable iff (!aresetn)
        tq_tick |=> div_r == 8'h00 && !tq_tick)
        else $error("quantum divider did not wrap");
    a_hard_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        tq_tick && hard_sync |=> q_r == 5'h1)
        else $error("hard sync did not restart bit");
    a_bit_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_start && !resync |=> q_r == 5'h0)
        else $error("bit did not wrap to sync");
    a_bit_length: assert property (@(posedge aclk) disable iff (!aresetn)
        q_r <= 5'h1C)
        else $error("quantum index beyond bit");
    a_ipt_room: assert property (@(posedge aclk) disable iff (!aresetn)
        seg_end >= 5'(spt_c + ipt_q))
        else $error("phase 2 shorter than processing time");
    a_lengthen_p1: assert property (@(posedge aclk) disable iff (!aresetn)
        resync && pos_err && err_mag > 5'(sjw_q) |=>
        ext_r == $past(sjw_q))
        else $error("phase 1 not lengthened by jump width");
    a_shorten_p2: assert property (@(posedge aclk) disable iff (!aresetn)
        resync && neg_err && err_mag > 5'(sjw_q) && !bit_end |=>
        shr_r == $past(sjw_q))
        else $error("phase 2 not shortened by jump width");
    a_hard_once: assert property (@(posedge aclk) disable iff (!aresetn)
        hard_done_r && !wakeup |=> hard_done_r)
        else $error("hard sync rearmed without wakeup");
    a_sample_val: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_strobe |=> rx_bit == !$past(rx_dom))
        else $error("sample not taken");
    a_drop_msg: assert property (@(posedge aclk) disable iff (!aresetn)
        msg_store && newdata_r && !chdef_r[CBT_CH_OVW] |=>
        msg_discard && !msg_accept)
        else $error("message not discarded");
    a_stamp_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_eof && chdef_r[CBT_CH_TSEL] |=>
        stamp_r == $past(timer_value))
        else $error("timestamp missed end of frame");
    a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write not answered");
endmodule : cbt_core
`default_nettype wire

// ==== sim/cbt_bus_node.sv ====
// Far-side CAN node model: drives the shared bus level seen on the rx pin
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
    input wire logic dom_high,
    input wire logic drive_dom,
    output logic pin
);
    // Released bus rests recessive, as the bus termination pulls it there
    always_comb begin
        pin = drive_dom ? dom_high : ~dom_high;
    end
endmodule : cbt_bus_node
`default_nettype wire

// ==== sim/can_bit_timing_sync_tb.sv ====
// Self-checking testbench for the CAN bit timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module can_bit_timing_sync_tb;
    import cbt_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, can_rx_pin, can_tx_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, buf_mask_sel, buf_channel;
    logic tx_active, tx_bit, bus_idle, wakeup, frame_sof, frame_eof;
    logic msg_store, msg_accept, msg_discard, bit_start, sample_strobe;
    logic rx_bit, buf_is_tx, buf_is_rx, buf_mask_use, buf_diag;
    logic [15:0] timer_value;
    logic rxpol, node_dom; // Far node polarity and drive
    int n_fail = 0, checks_done = 0, cyc = 0;
    int exp_q[$]; // Expected message outcomes
    logic [1:0] r;
    logic [31:0] d;
    int a, dbt, len, n, nd, ts;
    logic [15:0] v1, v2;
    cbt_core DUT (.*);
    cbt_bus_node NODE (.dom_high(rxpol), .drive_dom(node_dom),
        .pin(can_rx_pin));
    // Free-running clock, 100 MHz
    always #5 aclk = ~aclk;
    // Hang guard; whole run is well below this
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 40000) begin
            n_fail++;
            conclude();
        end
    end
    // Write one word, release each channel when taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        logic pa, pw, ta, tw;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ta = 0;
        tw = 0;
        do begin
            #1;
            pa = s_axi_awvalid & s_axi_awready;
            pw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (pa) s_axi_awvalid <= 1'b0;
            if (pw) s_axi_wvalid <= 1'b0;
            ta |= pa;
            tw |= pw;
        end while (!(ta && tw));
        do begin
            #1;
            pa = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!pa);
        s_axi_bready <= 1'b0;
    endtask : wr
    // Read one word
    task automatic rd(input logic [7:0] ad);
        logic p;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            #1;
            p = s_axi_arvalid & s_axi_arready;
            @(posedge aclk);
        end while (!p);
        s_axi_arvalid <= 1'b0;
        do begin
            #1;
            p = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!p);
        s_axi_rready <= 1'b0;
    endtask : rd
    // Wait for a one-cycle pulse: 0 bit start, 1 sample strobe
    task automatic wait_p(input int which);
        for (int i = 0; i < 4000; i++) begin
            @(posedge aclk);
            #1;
            if (which ? sample_strobe : bit_start) break;
        end
        // Sampled bit settles one edge after the strobe
        if (which) begin
            @(posedge aclk);
            #1;
        end
    endtask : wait_p
    // One-cycle pulse on a frame or store input
    task automatic pulse(input int which);
        @(posedge aclk);
        if (which == 0) frame_sof <= 1'b1;
        else if (which == 1) frame_eof <= 1'b1;
        else msg_store <= 1'b1;
        @(posedge aclk);
        frame_sof <= 1'b0;
        frame_eof <= 1'b0;
        msg_store <= 1'b0;
    endtask : pulse
    // Single end of run
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, tx_active, tx_bit, bus_idle, wakeup} = '0;
        {frame_sof, frame_eof, msg_store, rxpol, node_dom} = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        timer_value = 16'h0000;
        void'($urandom(16747));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, read-back of random values, unmapped place
        rd(CBT_OFF_PRESCALE); `CHK(d[8:0], CBT_PRE_RST)
        rd(CBT_OFF_SYNC); `CHK(d[15:0], CBT_SYNC_RST)
        rd(CBT_OFF_CHDEF); `CHK(d[3:0], CBT_CHDEF_RST)
        v1 = 16'($urandom());
        wr(CBT_OFF_SYNC, {20'h0, v1[11:0]});
        rd(CBT_OFF_SYNC); `CHK(d[11:0], v1[11:0])
        wr(8'h18, 32'hFFFFFFFF); `CHK(r, CBT_RESP_SLVERR)
        rd(8'h18); `CHK({r, d}, {CBT_RESP_SLVERR, 32'h0})
        $display("test registers done");
        // Every buffer type and owner code
        exp_q.delete();
        for (int t = 0; t < 8; t++) begin
            if (t == 6) continue;
            for (int o = 0; o < 3; o++) begin
                wr(CBT_OFF_BUFCFG, 32'(o * 8 + t));
                `CHK({buf_is_tx, buf_is_rx, buf_diag}, {t == 0, t > 0 && t < 6, t == 7})
                `CHK(buf_mask_use, 1'(t > 1 && t < 6))
                if (t > 1 && t < 6) `CHK(buf_mask_sel, 2'(t - 2))
                `CHK(buf_channel, 2'(o))
            end
        end
        $display("test buffer decode done");
        // Bit length, prescaler and transmit polarity
        for (int k = 0; k < 4; k++) begin
            a = $urandom_range(0, 3);
            dbt = $urandom_range(7, 24);
            // Bit 6 counts only with range extension (k == 3)
            wr(CBT_OFF_PRESCALE, 32'(a + 64 * (k / 2)) | 32'(k / 3 * 256));
            if (k == 3) a += 64;
            wr(CBT_OFF_SYNC, 32'(4 * 32 + dbt));
            wr(CBT_OFF_CHDEF, 32'((k % 2) * 4));
            tx_active <= 1'b1;
            tx_bit <= k[1];
            wait_p(0);
            n = 0;
            do begin
                @(posedge aclk);
                #1;
                n++;
            end while (!bit_start && n < 4000);
            len = ((dbt > 4 + (a == 0 ? 2 : 1)) ? dbt : 6) + 1;
            `CHK(n, len * 2 * (a + 1))
            @(posedge aclk);
            #1;
            `CHK(can_tx_pin, 1'(k[1] ^ (k % 2)))
        end
        tx_active <= 1'b0;
        $display("test bit timing done");
        // Receive sampling under both receive polarities
        wr(CBT_OFF_PRESCALE, 32'h0);
        wr(CBT_OFF_SYNC, 32'h00000087);
        pulse(3);
        for (int p = 0; p < 2; p++) begin
            wr(CBT_OFF_CHDEF, 32'(p * 8));
            rxpol <= p[0];
            bus_idle <= 1'b1;
            node_dom <= 1'b1;
            repeat (2) wait_p(1);
            `CHK(rx_bit, 1'b0)
            node_dom <= 1'b0;
            repeat (3) wait_p(1);
            `CHK(rx_bit, 1'b1)
            // Busy bus, edge after a recessive sample: resync path
            bus_idle <= 1'b0;
            node_dom <= 1'b1;
            repeat (2) wait_p(1);
            `CHK(rx_bit, 1'b0)
        end
        $display("test receive done");
        // New-data overwrite behaviour, model kept as a queue
        wr(CBT_OFF_STATUS, 32'h1);
        nd = 0;
        for (int i = 0; i < 4; i++) begin
            if (i == 2) wr(CBT_OFF_STATUS, 32'h1);
            if (i == 2) nd = 0;
            wr(CBT_OFF_CHDEF, (i == 3) ? 32'h2 : 32'h0);
            exp_q.push_back((i == 3 || nd == 0) ? 1 : 0);
            nd = 1;
            pulse(2);
            #1;
            `CHK({msg_accept, msg_discard}, exp_q[0] ? 2'h2 : 2'h1)
            void'(exp_q.pop_front());
            rd(CBT_OFF_STATUS); `CHK(d[0], 1'b1)
        end
        $display("test overwrite done");
        // Timestamp at start or end of frame
        for (ts = 0; ts < 2; ts++) begin
            wr(CBT_OFF_CHDEF, 32'(ts));
            v1 = 16'($urandom());
            v2 = ~v1;
            timer_value <= v1;
            pulse(0);
            @(posedge aclk);
            timer_value <= v2;
            pulse(1);
            rd(CBT_OFF_STAMP); `CHK(d[15:0], ts ? v2 : v1)
        end
        $display("test timestamp done");
        conclude();
    end
endmodule : can_bit_timing_sync_tb
`default_nettype wire
